// file: supply_cmp_pkg.sv
package supply_cmp_pkg;
    localparam logic [31:0] supply_monitor_ctrl_addr      = 32'hffff_0440;
    localparam logic [31:0] voltage_comparator_ctrl_addr  = 32'hffff_0444;
    localparam logic [15:0] supply_monitor_ctrl_reset     = 16'h0008;
    localparam logic [15:0] voltage_comparator_ctrl_reset = 16'h0000;
    // Supply monitor fields
    localparam int supply_low_flag_bit     = 0;
    localparam int supply_monitor_on_bit   = 1;
    localparam int trip_level_select_bit   = 2;
    localparam int supply_above_trip_bit   = 3;
    // Comparator fields
    localparam int fall_edge_flag_bit      = 0;
    localparam int rise_edge_flag_bit      = 1;
    localparam int hysteresis_on_bit       = 2;
    localparam int response_speed_lsb      = 3;
    localparam int result_polarity_bit     = 5;
    localparam int result_routing_lsb      = 6;
    localparam int negative_input_lsb      = 8;
    localparam int comparator_power_on_bit = 10;
    localparam logic [10:0] comparator_writable_mask = 11'h7fc;
    // Routing codes
    localparam logic [1:0] routing_pin = 2'h2;
    localparam logic [1:0] routing_irq = 2'h3;
endpackage

// file: supply_monitor_comparator_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// - Supply-low flag sets when supply comparator output goes low.
// - No timeout on clearing supply-low flag after comparator returns high.
// - Bit 3 reads supply comparator directly; 1 above trip or off.
// - Bit 2 selects trip point: 0 low level, 1 high level.
// - Bit 1 powers supply monitor on or off.
// - Supply flag raises interrupt only when a core enable is set.
// - Comparator register is 16 bits; bits 15 to 11 reserved.
// - Bit 10 powers the voltage comparator on or off.
// - Bits 9:8 choose negative input; code 11 reserved.
// - Bits 7:6 route result: 10 to pin, 11 to interrupt.
// - Bit 5 inverts the comparator output sense.
// - Bit 2 turns comparator hysteresis on or off.
// - Rising-edge flag sets on each rise; write 1 clears it.
// - Falling-edge flag sets on each fall and stays until cleared.
// - Result serves interrupt, logic array, conversion trigger, or pin.
// - Positive input shares the second analog input channel multiplexer.
module supply_monitor_comparator_ctrl (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [31:0] bus_addr,
    input  wire logic [15:0] bus_wdata,
    input  wire logic        bus_write,
    input  wire logic        bus_read,
    output logic      [15:0] bus_rdata,
    input  wire logic        supply_cmp_raw,
    input  wire logic        voltage_cmp_raw,
    input  wire logic        normal_irq_enable,
    input  wire logic        fast_irq_enable,
    output logic             supply_monitor_on,
    output logic             trip_level_select,
    output logic             comparator_power_on,
    output logic      [1:0]  negative_input_select,
    output logic             result_polarity,
    output logic      [1:0]  response_speed,
    output logic             hysteresis_on,
    output logic             positive_in_to_comparator,
    output logic             comparator_result_pin,
    output logic             comparator_irq,
    output logic             comparator_result,
    output logic             supply_low_irq,
    output logic             supply_low_fiq
);

    ////////////////////////////////////////////////////////////////////////////
    logic        sup_meta_reg;
    logic        sup_sync_reg;
    logic        sup_prev_reg;
    logic        cmp_meta_reg;
    logic        cmp_sync_reg;
    logic        cmp_prev_reg;
    logic        supply_low_flag_reg;
    logic        rise_flag_reg;
    logic        fall_flag_reg;
    logic [10:2] cmp_cfg_reg;
    logic [2:1]  psm_cfg_reg;
    logic        wr_psm;
    logic        wr_cmp;
    logic        cmp_view;
    logic        sup_view;

    assign wr_psm = bus_write && (bus_addr == supply_cmp_pkg::supply_monitor_ctrl_addr);
    assign wr_cmp = bus_write && (bus_addr == supply_cmp_pkg::voltage_comparator_ctrl_addr);

    ////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sup_meta_reg <= 1'b1;
            sup_sync_reg <= 1'b1;
            sup_prev_reg <= 1'b1;
            cmp_meta_reg <= 1'b0;
            cmp_sync_reg <= 1'b0;
            cmp_prev_reg <= 1'b0;
        end else begin
            sup_meta_reg <= supply_cmp_raw;
            sup_sync_reg <= sup_meta_reg;
            sup_prev_reg <= sup_view;
            cmp_meta_reg <= voltage_cmp_raw;
            cmp_sync_reg <= cmp_meta_reg;
            cmp_prev_reg <= cmp_view;
        end
    end

    // Powered-down monitor reads as above trip
    assign sup_view = sup_sync_reg | ~psm_cfg_reg[1];
    assign cmp_view = comparator_power_on & (cmp_sync_reg ^ cmp_cfg_reg[5]);

    ////////////////////////////////////////////////////////////////////////////
    // Trip level and monitor enable
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            psm_cfg_reg <= supply_cmp_pkg::supply_monitor_ctrl_reset[2:1];
        end else if (wr_psm) begin
            psm_cfg_reg <= bus_wdata[2:1];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cmp_cfg_reg <= supply_cmp_pkg::voltage_comparator_ctrl_reset[10:2];
        end else if (wr_cmp) begin
            cmp_cfg_reg <= bus_wdata[10:2];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Supply-low flag; set wins over clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            supply_low_flag_reg <= 1'b0;
        end else if (sup_prev_reg && !sup_view) begin
            supply_low_flag_reg <= 1'b1;
        end else if (wr_psm && bus_wdata[supply_cmp_pkg::supply_low_flag_bit] && sup_view) begin
            // Clear by write 1 only while comparator high, no delay
            supply_low_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rise_flag_reg <= 1'b0;
        end else if (cmp_view && !cmp_prev_reg) begin
            rise_flag_reg <= 1'b1;
        end else if (wr_cmp && bus_wdata[supply_cmp_pkg::rise_edge_flag_bit]) begin
            rise_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fall_flag_reg <= 1'b0;
        end else if (!cmp_view && cmp_prev_reg) begin
            fall_flag_reg <= 1'b1;
        end else if (wr_cmp && bus_wdata[supply_cmp_pkg::fall_edge_flag_bit]) begin
            fall_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            supply_monitor_on         <= 1'b0;
            trip_level_select         <= 1'b0;
            comparator_power_on       <= 1'b0;
            negative_input_select     <= 2'h0;
            result_polarity           <= 1'b0;
            response_speed            <= 2'h0;
            hysteresis_on             <= 1'b0;
            positive_in_to_comparator <= 1'b0;
            comparator_result_pin     <= 1'b0;
            comparator_irq            <= 1'b0;
            comparator_result         <= 1'b0;
            supply_low_irq            <= 1'b0;
            supply_low_fiq            <= 1'b0;
        end else begin
            supply_monitor_on         <= psm_cfg_reg[1];
            trip_level_select         <= psm_cfg_reg[2];
            comparator_power_on       <= cmp_cfg_reg[10];
            // Reserved code 11 keeps the negative input at half supply
            negative_input_select     <= (cmp_cfg_reg[9:8] == 2'h3) ? 2'h0 : cmp_cfg_reg[9:8];
            result_polarity           <= cmp_cfg_reg[5];
            response_speed            <= cmp_cfg_reg[4:3];
            hysteresis_on             <= cmp_cfg_reg[2];
            // Share positive input with analog channel while powered
            positive_in_to_comparator <= cmp_cfg_reg[10];
            comparator_result_pin     <= (cmp_cfg_reg[7:6] == supply_cmp_pkg::routing_pin) & cmp_view;
            comparator_irq            <= (cmp_cfg_reg[7:6] == supply_cmp_pkg::routing_irq) &
                                         (rise_flag_reg | fall_flag_reg);
            // Result for logic array and conversion trigger
            comparator_result         <= cmp_view;
            // Gated onto normal and fast interrupts
            supply_low_irq            <= supply_low_flag_reg & normal_irq_enable;
            supply_low_fiq            <= supply_low_flag_reg & fast_irq_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port, one cycle latency; unmapped reads return zero
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_rdata <= 16'h0000;
        end else if (bus_read && bus_addr == supply_cmp_pkg::supply_monitor_ctrl_addr) begin
            bus_rdata <= {12'h000, sup_view, psm_cfg_reg, supply_low_flag_reg};
        end else if (bus_read && bus_addr == supply_cmp_pkg::voltage_comparator_ctrl_addr) begin
            bus_rdata <= {5'h00, cmp_cfg_reg, rise_flag_reg, fall_flag_reg};
        end else begin
            bus_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_supply_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (sup_prev_reg && !sup_view) |=> supply_low_flag_reg)
        else $error("supply flag not set on fall");
    a_supply_flag_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (supply_low_flag_reg && !sup_view) |=> supply_low_flag_reg)
        else $error("supply flag cleared while low");
    a_supply_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_psm && bus_wdata[0] && sup_view && sup_prev_reg) |=> !supply_low_flag_reg)
        else $error("supply flag clear delayed");
    a_supply_read_bit: assert property (@(posedge mclk) disable iff (!rst_n)
        (bus_read && bus_addr == supply_cmp_pkg::supply_monitor_ctrl_addr) |=> bus_rdata[3] == $past(sup_view))
        else $error("status bit mismatch");
    a_monitor_off_high: assert property (@(posedge mclk) disable iff (!rst_n)
        !psm_cfg_reg[1] |-> sup_view)
        else $error("powered down monitor reads low");
    a_irq_gated: assert property (@(posedge mclk) disable iff (!rst_n)
        supply_low_irq |-> $past(normal_irq_enable) && $past(supply_low_flag_reg))
        else $error("irq without enable");
    a_cmp_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        bus_rdata[15:11] == 5'h00)
        else $error("reserved bits nonzero");
    a_rise_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (cmp_view && !cmp_prev_reg) |=> rise_flag_reg)
        else $error("rise flag missed");
    a_fall_flag_set: assert property (@(posedge mclk) disable iff (!rst_n)
        (!cmp_view && cmp_prev_reg) |=> fall_flag_reg)
        else $error("fall flag missed");
    a_fall_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_cmp && bus_wdata[0] && !(!cmp_view && cmp_prev_reg)) |=> !fall_flag_reg)
        else $error("fall flag not cleared");
    a_pin_routing: assert property (@(posedge mclk) disable iff (!rst_n)
        comparator_result_pin |-> $past(cmp_cfg_reg[7:6]) == supply_cmp_pkg::routing_pin)
        else $error("pin driven without routing");
    a_rise_flag_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_cmp && bus_wdata[supply_cmp_pkg::rise_edge_flag_bit] && !(cmp_view && !cmp_prev_reg)) |=> !rise_flag_reg)
        else $error("rise flag not cleared");
    a_rise_flag_keep: assert property (@(posedge mclk) disable iff (!rst_n)
        (rise_flag_reg && !(wr_cmp && bus_wdata[supply_cmp_pkg::rise_edge_flag_bit])) |=> rise_flag_reg)
        else $error("rise flag lost");
    a_fall_flag_keep: assert property (@(posedge mclk) disable iff (!rst_n)
        (fall_flag_reg && !(wr_cmp && bus_wdata[supply_cmp_pkg::fall_edge_flag_bit])) |=> fall_flag_reg)
        else $error("fall flag lost");
    a_supply_flag_keep: assert property (@(posedge mclk) disable iff (!rst_n)
        (supply_low_flag_reg && !(wr_psm && bus_wdata[supply_cmp_pkg::supply_low_flag_bit])) |=> supply_low_flag_reg)
        else $error("supply flag lost");
    a_off_no_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (!psm_cfg_reg[1] && !supply_low_flag_reg) |=> !supply_low_flag_reg)
        else $error("supply flag set while monitor off");
    a_trip_level_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_psm |=> ##1 trip_level_select == $past(bus_wdata[supply_cmp_pkg::trip_level_select_bit], 2))
        else $error("trip level not applied");
    a_monitor_on_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_psm |=> ##1 supply_monitor_on == $past(bus_wdata[supply_cmp_pkg::supply_monitor_on_bit], 2))
        else $error("monitor enable not applied");
    a_power_on_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_cmp |=> ##1 comparator_power_on == $past(bus_wdata[supply_cmp_pkg::comparator_power_on_bit], 2))
        else $error("comparator power not applied");
    a_hysteresis_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_cmp |=> ##1 hysteresis_on == $past(bus_wdata[supply_cmp_pkg::hysteresis_on_bit], 2))
        else $error("hysteresis not applied");
    a_polarity_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        wr_cmp |=> ##1 result_polarity == $past(bus_wdata[supply_cmp_pkg::result_polarity_bit], 2))
        else $error("polarity not applied");
    a_neg_input_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_cmp && bus_wdata[9:8] != 2'h3) |=> ##1 negative_input_select == $past(bus_wdata[9:8], 2))
        else $error("negative input not applied");
    a_neg_input_legal: assert property (@(posedge mclk) disable iff (!rst_n)
        negative_input_select != 2'h3)
        else $error("reserved negative input driven");
    a_irq_routing: assert property (@(posedge mclk) disable iff (!rst_n)
        comparator_irq |-> $past(cmp_cfg_reg[7:6]) == supply_cmp_pkg::routing_irq)
        else $error("irq without routing");
    a_fiq_gated: assert property (@(posedge mclk) disable iff (!rst_n)
        supply_low_fiq |-> $past(fast_irq_enable) && $past(supply_low_flag_reg))
        else $error("fast irq without enable");
    a_result_off_low: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(comparator_power_on) |-> !comparator_result)
        else $error("result high while comparator off");
    a_pos_in_follow: assert property (@(posedge mclk) disable iff (!rst_n)
        positive_in_to_comparator == comparator_power_on)
        else $error("positive input select mismatch");
    a_rdata_idle_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(bus_read) |-> bus_rdata == 16'h0000)
        else $error("read data outside read cycle");
    a_supply_read_flag: assert property (@(posedge mclk) disable iff (!rst_n)
        (bus_read && bus_addr == supply_cmp_pkg::supply_monitor_ctrl_addr) |=>
            bus_rdata[0] == $past(supply_low_flag_reg))
        else $error("supply flag read mismatch");
    a_cmp_read_flags: assert property (@(posedge mclk) disable iff (!rst_n)
        (bus_read && bus_addr == supply_cmp_pkg::voltage_comparator_ctrl_addr) |=>
            bus_rdata[1] == $past(rise_flag_reg) && bus_rdata[0] == $past(fall_flag_reg))
        else $error("edge flags read mismatch");

    ////////////////////////////////////////////////////////////////////////////
    // Cover points
    c_supply_drop: cover property (@(posedge mclk) disable iff (!rst_n) sup_prev_reg && !sup_view);
    c_rise_clear: cover property (@(posedge mclk) disable iff (!rst_n) rise_flag_reg ##1 !rise_flag_reg);
    c_cmp_irq: cover property (@(posedge mclk) disable iff (!rst_n) comparator_irq);
    c_fall_clear: cover property (@(posedge mclk) disable iff (!rst_n) fall_flag_reg ##1 !fall_flag_reg);
    c_supply_clear: cover property (@(posedge mclk) disable iff (!rst_n) supply_low_flag_reg ##1 !supply_low_flag_reg);

endmodule

// file: analog_front_model.sv
`timescale 1ns/1ps
module analog_front_model (
    input  wire logic supply_ok,
    input  wire logic cmp_level,
    input  wire logic monitor_on,
    input  wire logic cmp_on,
    output wire logic supply_cmp_raw,
    output wire logic voltage_cmp_raw
);
    logic idle_t = 1'b0;
    always #13 idle_t = ~idle_t;
    assign #3 supply_cmp_raw = monitor_on ? supply_ok : 1'b1;
    assign #3 voltage_cmp_raw = cmp_on ? cmp_level : idle_t;
endmodule

// file: supply_monitor_comparator_ctrl_tb.sv
`timescale 1ns/1ps
module supply_monitor_comparator_ctrl_tb;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] bus_addr = '0;
    logic [15:0] bus_wdata = '0;
    logic        bus_write = 1'b0;
    logic        bus_read = 1'b0;
    logic [15:0] bus_rdata;
    logic        supply_ok = 1'b1;
    logic        cmp_level = 1'b0;
    logic        n_en = 1'b0;
    logic        f_en = 1'b0;
    wire         s_raw, v_raw;
    logic        mon_on, trip, cmp_on, pol, hyst, pos_in, pin, cirq, cres, lirq, lfiq;
    logic [1:0]  nsel, speed;
    int          n_mismatch = 0;
    int          compares = 0;
    localparam logic [31:0] sa = supply_cmp_pkg::supply_monitor_ctrl_addr;
    localparam logic [31:0] ca = supply_cmp_pkg::voltage_comparator_ctrl_addr;
    always #4 mclk = ~mclk;
    supply_monitor_comparator_ctrl dut (.mclk(mclk), .rst_n(rst_n), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
        .supply_cmp_raw(s_raw), .voltage_cmp_raw(v_raw), .normal_irq_enable(n_en),
        .fast_irq_enable(f_en), .supply_monitor_on(mon_on), .trip_level_select(trip),
        .comparator_power_on(cmp_on), .negative_input_select(nsel), .result_polarity(pol),
        .response_speed(speed), .hysteresis_on(hyst), .positive_in_to_comparator(pos_in),
        .comparator_result_pin(pin), .comparator_irq(cirq), .comparator_result(cres),
        .supply_low_irq(lirq), .supply_low_fiq(lfiq));
    analog_front_model partner (.supply_ok(supply_ok), .cmp_level(cmp_level), .monitor_on(mon_on),
        .cmp_on(cmp_on), .supply_cmp_raw(s_raw), .voltage_cmp_raw(v_raw));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge mclk);
        bus_write <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, input logic [15:0] exp);
        @(posedge mclk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge mclk);
        bus_read <= 1'b0;
        #1 chk(bus_rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        rd(sa, 16'h0008);
        rd(ca, 16'h0000);
        wr(32'hffff_0448, 16'hffff);
        rd(32'hffff_0448, 16'h0000);
        wr(ca, 16'hfbfc);
        rd(ca, 16'h03fc);
        chk({9'h000, hyst, pol, speed, nsel, cmp_on}, 16'h0078);
        for (int i = 0; i < 4; i++) begin
            wr(ca, {6'h00, i[1:0], 8'h00});
            cyc(2);
            chk({14'h0000, nsel}, (i == 3) ? 16'h0000 : 16'(i));
        end
        // Power up, drop any flags caught while the output settled
        wr(ca, 16'h0580);
        cyc(6);
        chk({14'h0000, cmp_on, pos_in}, 16'h0003);
        wr(ca, 16'h0583);
        rd(ca, 16'h0580);
        cmp_level <= 1'b1;
        cyc(6);
        chk({14'h0000, pin, cres}, 16'h0003);
        rd(ca, 16'h0582);
        cmp_level <= 1'b0;
        cyc(6);
        rd(ca, 16'h0583);
        wr(ca, 16'h0582);
        rd(ca, 16'h0581);
        wr(ca, 16'h0581);
        rd(ca, 16'h0580);
        wr(ca, 16'h05c0);
        cmp_level <= 1'b1;
        cyc(6);
        chk({14'h0000, cirq, pin}, 16'h0002);
        wr(ca, 16'h05c3);
        cyc(2);
        chk({15'h0000, cirq}, 16'h0000);
        wr(ca, 16'h05e0);
        cyc(6);
        chk({15'h0000, cres}, 16'h0000);
        rd(ca, 16'h05e1);
        // Supply monitor
        wr(sa, 16'h0002);
        cyc(2);
        chk({15'h0000, mon_on}, 16'h0001);
        rd(sa, 16'h000a);
        @(posedge mclk);
        n_en <= 1'b1;
        supply_ok <= 1'b0;
        cyc(6);
        rd(sa, 16'h0003);
        chk({14'h0000, lirq, lfiq}, 16'h0002);
        @(posedge mclk);
        n_en <= 1'b0;
        f_en <= 1'b1;
        cyc(2);
        chk({14'h0000, lirq, lfiq}, 16'h0001);
        wr(sa, 16'h0003);
        rd(sa, 16'h0003);
        supply_ok <= 1'b1;
        cyc(5);
        rd(sa, 16'h000b);
        wr(sa, 16'h0007);
        rd(sa, 16'h000e);
        chk({14'h0000, trip, lfiq}, 16'h0002);
        wr(sa, 16'h0000);
        cyc(2);
        supply_ok <= 1'b0;
        cyc(5);
        rd(sa, 16'h0008);
        report_and_stop();
    end
endmodule
